//--- inc/qodfr_pkg.sv
package qodfr_pkg;

   // ---------------------------------------------------------------
   // Instruction codes
   // ---------------------------------------------------------------
   localparam logic [7:0] QUAD_OUTPUT_READ_CMD = 8'h6b;
   localparam logic [7:0] QUAD_OUTPUT_READ_WIDE_ADDR_CMD = 8'h6c;
   localparam logic [7:0] DUAL_IO_READ_CMD = 8'hbb;
   localparam logic [7:0] DUAL_IO_READ_WIDE_ADDR_CMD = 8'hbc;

   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
   localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
   localparam logic [5:0] MODE_BITS = 6'h08;
   localparam logic [5:0] STEP_SINGLE = 6'h01;
   localparam logic [5:0] STEP_DUAL = 6'h02;
   localparam logic [5:0] SHORT_FRAME_EDGES = 6'h08;
   localparam logic [5:0] EDGE_COUNT_MAX = 6'h3f;
   localparam logic [3:0] CONT_MODE_NIBBLE = 4'ha;
   localparam logic [1:0] LANES_QUAD = 2'h1;
   localparam logic [1:0] LANES_DUAL = 2'h3;
   localparam logic [3:0] OE_QUAD = 4'hf;
   localparam logic [3:0] OE_DUAL = 4'h3;
   localparam logic [7:0] UNDERRUN_BYTE = 8'hff;

   // ---------------------------------------------------------------
   // Dummy cycles per latency code
   // ---------------------------------------------------------------
   localparam logic [3:0] QUAD_DUMMY_TBL [0:3] = '{4'h8, 4'h8, 4'h8, 4'h0};
   localparam logic [3:0] DUAL_HP_DUMMY_TBL [0:3] = '{4'h4, 4'h4, 4'h4, 4'h0};
   localparam logic [3:0] DUAL_EH_DUMMY_TBL [0:3] = '{4'h4, 4'h4, 4'h5, 4'h1};

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_CMD = 7'h02,
      ST_ADDR = 7'h04,
      ST_MODE = 7'h08,
      ST_DUMMY = 7'h10,
      ST_DATA = 7'h20,
      ST_IGNORE = 7'h40
   } qodfr_state_e;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic [3:0] io;
   } qodfr_pins_s;

   typedef struct packed {
      logic four_byte_address_enable;
      logic quad_enable;
      logic enhanced_latency_table;
      logic [1:0] latency_code;
   } qodfr_cfg_s;

   function automatic logic [3:0] dummy_cycles(input logic quad, input qodfr_cfg_s cfg);
      if (quad) begin
         return QUAD_DUMMY_TBL[cfg.latency_code];
      end
      if (cfg.enhanced_latency_table) begin
         return DUAL_EH_DUMMY_TBL[cfg.latency_code];
      end
      return DUAL_HP_DUMMY_TBL[cfg.latency_code];
   endfunction : dummy_cycles

endpackage : qodfr_pkg

//--- rtl/qodfr_read.sv
`timescale 1ns/1ps
// Summary of operation
// - Quad read: legacy code takes 3 or 4 address bytes per enable; alternate always 4.
// - Quad read returns one nibble per clock on IO0-IO3, changed on falling SCK.
// - Dummy cycles follow the quad address; IO lines are ignored during them.
// - Reads start at any byte, address increments per byte and wraps to zero.
// - Quad read only works when the quad enable bit is set.
// - Dual read: legacy code takes 3 or 4 address bytes per enable; alternate always 4.
// - Dual read address arrives two bits per rising SCK on IO0 and IO1.
// - High-performance table: instruction, address, latency, no mode cycles.
// - Enhanced table: instruction, address, four mode cycles, then latency.
// - Mode upper nibble A: next frame is a dual read starting at the address.
// - Only the mode byte's upper nibble is decoded; lower nibble ignored.
// - Any other upper nibble leaves continuous mode at the next select release.
// - A frame of eight clocks or fewer without valid sequence leaves continuous mode.
// - Dual read returns two bits per clock on IO0 and IO1, changed on falling SCK.
// - Dual read dummy count comes from the latency code.
// - Four-byte address enable makes the legacy codes take four address bytes.
// - Dummies count fall to fall; zero dummies drives data on the first fall.
// - Releasing select ends a read at any point of the data stream.
module qodfr_read #(
   parameter int ADDR_BITS = 25,
   parameter int FIFO_DEPTH = 2
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Serial link pins
   input wire logic SCK_I,
   input wire logic CS_N_I,
   input wire logic [3:0] IO_I,
   output logic [3:0] IO_O,
   output logic [3:0] IO_OE_O,
   // Configuration
   input wire logic FOUR_BYTE_ADDRESS_ENABLE_I,
   input wire logic QUAD_ENABLE_I,
   input wire logic ENHANCED_LATENCY_TABLE_I,
   input wire logic [1:0] LATENCY_CODE_I,
   // Status
   output logic CONTINUOUS_MODE_O,
   // Array read stream
   output logic [ADDR_BITS-1:0] MEM_ADDR_O,
   input wire logic [7:0] MEM_RDATA_I,
   input wire logic MEM_RVALID_I,
   output logic MEM_RREADY_O
);

   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

   // ---------------------------------------------------------------
   // Pin synchroniser
   // ---------------------------------------------------------------
   // SCK is sampled, so it must stay well below half the system clock.
   qodfr_pkg::qodfr_pins_s pins_s1, pins_s2, pins_s3;
   qodfr_pkg::qodfr_cfg_s cfg;
   logic sck_rise, sck_fall, cs_rise;
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         pins_s1 <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
         pins_s2 <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
         pins_s3 <= '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};
      end else begin
         pins_s1 <= '{cs_n: CS_N_I, sck: SCK_I, io: IO_I};
         pins_s2 <= pins_s1;
         pins_s3 <= pins_s2;
      end
   end
   assign sck_rise = pins_s2.sck & ~pins_s3.sck;
   assign sck_fall = ~pins_s2.sck & pins_s3.sck;
   assign cs_rise = pins_s2.cs_n & ~pins_s3.cs_n;
   assign cfg = '{four_byte_address_enable: FOUR_BYTE_ADDRESS_ENABLE_I,
                  quad_enable: QUAD_ENABLE_I,
                  enhanced_latency_table: ENHANCED_LATENCY_TABLE_I,
                  latency_code: LATENCY_CODE_I};
   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      return (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : ptr_inc
   // ---------------------------------------------------------------
   // Frame engine and byte buffer
   // ---------------------------------------------------------------
   qodfr_pkg::qodfr_state_e state, next_state;
   logic [7:0] cmd_sh, next_cmd_sh;
   logic [31:0] addr_sh, next_addr_sh;
   logic [7:0] mode_sh, next_mode_sh;
   logic [5:0] bit_cnt, next_bit_cnt;
   logic [5:0] rise_cnt, next_rise_cnt;
   logic [3:0] dcnt, next_dcnt;
   logic quad, next_quad;
   logic wide, next_wide;
   logic cont, next_cont;
   logic frame_cont, next_frame_cont;
   logic mode_seen, next_mode_seen;
   logic [3:0] mode_nib, next_mode_nib;
   logic [7:0] out_sh, next_out_sh;
   logic [1:0] lanes, next_lanes;
   logic [3:0] io_out, next_io_out;
   logic [3:0] io_oe, next_io_oe;
   logic [ADDR_BITS-1:0] mem_addr, next_mem_addr;
   logic rready, next_rready;
   logic [7:0] fifo_mem [FIFO_DEPTH];
   logic [7:0] next_fifo_mem [FIFO_DEPTH];
   logic [PW-1:0] rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
   logic [CW-1:0] count, next_count;
   logic push, pop, drive, addr_done;
   logic [7:0] byte_now;
   logic [5:0] addr_len;
   always_comb begin
      next_state = state;
      next_cmd_sh = cmd_sh;
      next_addr_sh = addr_sh;
      next_mode_sh = mode_sh;
      next_bit_cnt = bit_cnt;
      next_rise_cnt = rise_cnt;
      next_dcnt = dcnt;
      next_quad = quad;
      next_wide = wide;
      next_cont = cont;
      next_frame_cont = frame_cont;
      next_mode_seen = mode_seen;
      next_mode_nib = mode_nib;
      next_out_sh = out_sh;
      next_lanes = lanes;
      next_io_out = io_out;
      next_io_oe = io_oe;
      next_mem_addr = mem_addr;
      next_fifo_mem = fifo_mem;
      next_rd_ptr = rd_ptr;
      next_wr_ptr = wr_ptr;
      next_count = count;
      addr_done = 1'b0;
      addr_len = wide ? qodfr_pkg::ADDR_BITS_WIDE : qodfr_pkg::ADDR_BITS_NARROW;
      // Memory side fills the buffer; each accepted byte advances the address
      push = MEM_RVALID_I & rready;
      if (push) begin
         next_fifo_mem[wr_ptr] = MEM_RDATA_I;
         next_wr_ptr = ptr_inc(wr_ptr);
         next_mem_addr = mem_addr + ADDR_BITS'(1);
      end
      // Output shifter, one lane group per falling edge
      drive = sck_fall && !pins_s2.cs_n &&
              ((state == qodfr_pkg::ST_DUMMY && dcnt == 4'h0) ||
               state == qodfr_pkg::ST_DATA);
      pop = drive && lanes == 2'h0 && count != '0;
      byte_now = (count != '0) ? fifo_mem[rd_ptr] : qodfr_pkg::UNDERRUN_BYTE;
      if (pop) begin
         next_rd_ptr = ptr_inc(rd_ptr);
      end
      if (drive) begin
         next_state = qodfr_pkg::ST_DATA;
         next_io_oe = quad ? qodfr_pkg::OE_QUAD : qodfr_pkg::OE_DUAL;
         if (lanes == 2'h0) begin
            next_io_out = quad ? byte_now[7:4] : {2'b00, byte_now[7:6]};
            next_out_sh = quad ? {byte_now[3:0], 4'h0} : {byte_now[5:0], 2'b00};
            next_lanes = quad ? qodfr_pkg::LANES_QUAD : qodfr_pkg::LANES_DUAL;
         end else begin
            next_io_out = quad ? out_sh[7:4] : {2'b00, out_sh[7:6]};
            next_out_sh = quad ? {out_sh[3:0], 4'h0} : {out_sh[5:0], 2'b00};
            next_lanes = lanes - 2'h1;
         end
      end
      next_count = count + CW'(push) - CW'(pop);
      if (sck_rise && rise_cnt != qodfr_pkg::EDGE_COUNT_MAX) begin
         next_rise_cnt = rise_cnt + 6'h01;
      end
      if (pins_s2.cs_n) begin
         // Select high ends any read at once
         next_state = qodfr_pkg::ST_IDLE;
         next_io_oe = 4'h0;
         if (cs_rise && mode_seen) begin
            next_cont = (mode_nib == qodfr_pkg::CONT_MODE_NIBBLE);
         end else if (cs_rise && frame_cont && rise_cnt <= qodfr_pkg::SHORT_FRAME_EDGES) begin
            next_cont = 1'b0;
         end
      end else begin
         unique case (state)
            qodfr_pkg::ST_IDLE: begin
               next_state = cont ? qodfr_pkg::ST_ADDR : qodfr_pkg::ST_CMD;
               next_bit_cnt = '0;
               next_rise_cnt = '0;
               next_frame_cont = cont;
               next_mode_seen = 1'b0;
               next_addr_sh = '0;
               next_cmd_sh = '0;
               next_lanes = '0;
               next_quad = cont ? 1'b0 : quad;
            end
            qodfr_pkg::ST_CMD: begin
               if (sck_rise) begin
                  next_cmd_sh = {cmd_sh[6:0], pins_s2.io[0]};
                  next_bit_cnt = bit_cnt + qodfr_pkg::STEP_SINGLE;
                  if (next_bit_cnt == qodfr_pkg::CMD_BITS) begin
                     next_bit_cnt = '0;
                     next_state = qodfr_pkg::ST_ADDR;
                     next_quad = (next_cmd_sh == qodfr_pkg::QUAD_OUTPUT_READ_CMD ||
                                  next_cmd_sh == qodfr_pkg::QUAD_OUTPUT_READ_WIDE_ADDR_CMD);
                     next_wide = (next_cmd_sh == qodfr_pkg::QUAD_OUTPUT_READ_WIDE_ADDR_CMD ||
                                  next_cmd_sh == qodfr_pkg::DUAL_IO_READ_WIDE_ADDR_CMD ||
                                  cfg.four_byte_address_enable);
                     if (next_quad && !cfg.quad_enable) begin
                        next_state = qodfr_pkg::ST_IGNORE;
                     end else if (!next_quad && next_cmd_sh != qodfr_pkg::DUAL_IO_READ_CMD &&
                                  next_cmd_sh != qodfr_pkg::DUAL_IO_READ_WIDE_ADDR_CMD) begin
                        next_state = qodfr_pkg::ST_IGNORE;
                     end
                  end
               end
            end
            qodfr_pkg::ST_ADDR: begin
               if (sck_rise) begin
                  if (quad) begin
                     next_addr_sh = {addr_sh[30:0], pins_s2.io[0]};
                     next_bit_cnt = bit_cnt + qodfr_pkg::STEP_SINGLE;
                  end else begin
                     next_addr_sh = {addr_sh[29:0], pins_s2.io[1:0]};
                     next_bit_cnt = bit_cnt + qodfr_pkg::STEP_DUAL;
                  end
                  if (next_bit_cnt == addr_len) begin
                     addr_done = 1'b1;
                     next_bit_cnt = '0;
                     next_mem_addr = next_addr_sh[ADDR_BITS-1:0];
                     next_rd_ptr = '0;
                     next_wr_ptr = '0;
                     next_count = '0;
                     next_dcnt = qodfr_pkg::dummy_cycles(quad, cfg);
                     if (!quad && cfg.enhanced_latency_table) begin
                        next_state = qodfr_pkg::ST_MODE;
                     end else begin
                        next_state = qodfr_pkg::ST_DUMMY;
                     end
                  end
               end
            end
            qodfr_pkg::ST_MODE: begin
               if (sck_rise) begin
                  next_mode_sh = {mode_sh[5:0], pins_s2.io[1:0]};
                  next_bit_cnt = bit_cnt + qodfr_pkg::STEP_DUAL;
                  if (next_bit_cnt == qodfr_pkg::MODE_BITS) begin
                     next_mode_seen = 1'b1;
                     next_mode_nib = next_mode_sh[7:4];
                     next_state = qodfr_pkg::ST_DUMMY;
                  end
               end
            end
            qodfr_pkg::ST_DUMMY: begin
               // IO lines are not looked at while the latency runs
               if (sck_fall && dcnt != 4'h0) begin
                  next_dcnt = dcnt - 4'h1;
               end
            end
            qodfr_pkg::ST_DATA, qodfr_pkg::ST_IGNORE: begin
            end
            default: begin
               next_state = qodfr_pkg::ST_IDLE;
            end
         endcase
      end

      // Prefetch only once the start address is known
      next_rready = (next_state == qodfr_pkg::ST_MODE || next_state == qodfr_pkg::ST_DUMMY ||
                     next_state == qodfr_pkg::ST_DATA) && next_count < CW'(FIFO_DEPTH);
   end
   always_ff @(posedge CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state <= qodfr_pkg::ST_IDLE;
         cmd_sh <= '0;
         addr_sh <= '0;
         mode_sh <= '0;
         bit_cnt <= '0;
         rise_cnt <= '0;
         dcnt <= '0;
         quad <= 1'b0;
         wide <= 1'b0;
         cont <= 1'b0;
         frame_cont <= 1'b0;
         mode_seen <= 1'b0;
         mode_nib <= '0;
         out_sh <= '0;
         lanes <= '0;
         io_out <= '0;
         io_oe <= '0;
         mem_addr <= '0;
         rready <= 1'b0;
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            fifo_mem[i] <= '0;
         end
      end else begin
         state <= next_state;
         cmd_sh <= next_cmd_sh;
         addr_sh <= next_addr_sh;
         mode_sh <= next_mode_sh;
         bit_cnt <= next_bit_cnt;
         rise_cnt <= next_rise_cnt;
         dcnt <= next_dcnt;
         quad <= next_quad;
         wide <= next_wide;
         cont <= next_cont;
         frame_cont <= next_frame_cont;
         mode_seen <= next_mode_seen;
         mode_nib <= next_mode_nib;
         out_sh <= next_out_sh;
         lanes <= next_lanes;
         io_out <= next_io_out;
         io_oe <= next_io_oe;
         mem_addr <= next_mem_addr;
         rready <= next_rready;
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         count <= next_count;
         fifo_mem <= next_fifo_mem;
      end
   end
   assign IO_O = io_out;
   assign IO_OE_O = io_oe;
   assign CONTINUOUS_MODE_O = cont;
   assign MEM_ADDR_O = mem_addr;
   assign MEM_RREADY_O = rready;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);
   a_cs_release_oe: assert property (pins_s2.cs_n |=> IO_OE_O == 4'h0)
      else $error("outputs still enabled after select release");
   a_dummy_no_drive: assert property (state == qodfr_pkg::ST_DUMMY |-> IO_OE_O == 4'h0)
      else $error("lines driven during dummy cycles");
   a_io_on_fall: assert property ((IO_O != $past(IO_O)) |-> $past(sck_fall))
      else $error("data changed without a falling clock");
   a_quad_needs_qe: assert property (IO_OE_O == qodfr_pkg::OE_QUAD |-> cfg.quad_enable)
      else $error("quad data driven without quad enable");
   a_dual_two_lines: assert property (IO_OE_O == qodfr_pkg::OE_DUAL |-> !quad)
      else $error("dual width used for a quad read");
   a_hp_no_mode: assert property (!cfg.enhanced_latency_table
      && state == qodfr_pkg::ST_ADDR && addr_done |=> state != qodfr_pkg::ST_MODE)
      else $error("mode cycles taken with high performance table");
   a_mode_keep: assert property (cs_rise && mode_seen
      && mode_nib == qodfr_pkg::CONT_MODE_NIBBLE |=> CONTINUOUS_MODE_O)
      else $error("continuous mode not entered");
   a_mode_leave: assert property (cs_rise && mode_seen
      && mode_nib != qodfr_pkg::CONT_MODE_NIBBLE |=> !CONTINUOUS_MODE_O)
      else $error("continuous mode not left");
   a_short_exit: assert property (cs_rise && !mode_seen && frame_cont
      && rise_cnt <= qodfr_pkg::SHORT_FRAME_EDGES |=> !CONTINUOUS_MODE_O)
      else $error("short frame did not end continuous mode");
   a_addr_step: assert property (MEM_RVALID_I && MEM_RREADY_O && !addr_done
      |=> MEM_ADDR_O == $past(MEM_ADDR_O) + ADDR_BITS'(1))
      else $error("array address did not advance");
   a_addr_length: assert property (addr_done && !frame_cont
      |-> rise_cnt + 6'h01 == qodfr_pkg::CMD_BITS + (((cmd_sh[0] == 1'b0)
      || cfg.four_byte_address_enable) ? qodfr_pkg::ADDR_BITS_WIDE
      : qodfr_pkg::ADDR_BITS_NARROW) / (quad ? qodfr_pkg::STEP_SINGLE : qodfr_pkg::STEP_DUAL))
      else $error("address length wrong");
   c_quad_data: cover property (IO_OE_O == qodfr_pkg::OE_QUAD ##1 sck_fall);
   c_dual_cont: cover property (state == qodfr_pkg::ST_ADDR && frame_cont && addr_done);
   c_short_exit: cover property (cs_rise && frame_cont && !mode_seen);

endmodule : qodfr_read

//--- sim/qodfr_host_model.sv
`timescale 1ns/1ps
module qodfr_host_model (
   // Link pins
   output logic sck_o,
   output logic cs_n_o,
   output logic [3:0] io_o,
   output logic [3:0] oe_o,
   // Wire level and device enables
   input wire logic [3:0] io_i,
   input wire logic [3:0] dev_oe_i
);
   // ---------------------------------------------------------------
   // Host side of the link, mode 0, idle clock low
   // ---------------------------------------------------------------
   // 8 MHz keeps well below either read's frequency limit
   localparam realtime HALF = 62.5;
   logic [7:0] got [$];
   logic [3:0] oe_seen;

   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      io_o = 4'h0;
      oe_o = 4'h0;
   end

   task automatic clk_out(input logic [3:0] v, input logic [3:0] e);
      io_o = v;
      oe_o = e;
      #HALF sck_o = 1'b1;
      #HALF sck_o = 1'b0;
   endtask : clk_out

   task automatic frame(input bit use_cmd, input logic [7:0] cmd, input int nab,
         input logic [31:0] addr, input bit dual, input bit use_mode,
         input logic [7:0] mode, input int dum, input int nb);
      logic [7:0] b;
      got.delete();
      cs_n_o = 1'b0;
      #HALF;
      if (use_cmd) for (int i = 7; i >= 0; i--) clk_out({3'h0, cmd[i]}, 4'h1);
      for (int i = nab - 1; i >= 0; i -= (dual ? 2 : 1)) begin
         clk_out(dual ? {2'h0, addr[i -: 2]} : {3'h0, addr[i]}, dual ? 4'h3 : 4'h1);
      end
      // Lower mode nibble is left floating on purpose
      if (use_mode) for (int i = 7; i > 0; i -= 2) clk_out({2'h0, mode[i -: 2]},
         i > 3 ? 4'h3 : 4'h0);
      repeat (dum) clk_out(4'h0, 4'h0);
      // With no dummies this is the first data fall, the latest release allowed
      oe_o = 4'h0;
      repeat (nb) begin
         b = 8'h00;
         repeat (dual ? 4 : 2) begin
            #HALF sck_o = 1'b1;
            b = dual ? {b[5:0], io_i[1:0]} : {b[3:0], io_i};
            oe_seen = dev_oe_i;
            #HALF sck_o = 1'b0;
         end
         got.push_back(b);
      end
      cs_n_o = 1'b1;
      #(8 * HALF);
   endtask : frame

   task automatic glitch(input int n);
      cs_n_o = 1'b0;
      #HALF;
      repeat (n) clk_out(4'h0, 4'h3);
      cs_n_o = 1'b1;
      #(8 * HALF);
   endtask : glitch
endmodule : qodfr_host_model

//--- sim/tb_qodfr_read.sv
`timescale 1ns/1ps
module tb_qodfr_read;
   logic clk, rst, fbae, qen, elt, rvalid, sck, cs_n, cont, rready;
   logic [1:0] lc;
   logic [3:0] dev_io, dev_oe, h_io, h_oe, wire_io;
   logic [24:0] maddr;
   logic [31:0] a;
   int errors = 0;
   int n_checks = 0;
   int seed = 7;

   // ---------------------------------------------------------------
   // Wire, array and instances
   // ---------------------------------------------------------------
   // Released lines float high through pull-ups
   assign wire_io = (dev_oe & dev_io) | (~dev_oe & h_oe & h_io) | (~dev_oe & ~h_oe);

   function automatic logic [7:0] mem_byte(input logic [24:0] ad);
      return ad[7:0] ^ ad[15:8] ^ 8'h3c;
   endfunction : mem_byte

   qodfr_read dut (.CLK_I(clk), .RESET_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .IO_I(wire_io),
      .IO_O(dev_io), .IO_OE_O(dev_oe), .FOUR_BYTE_ADDRESS_ENABLE_I(fbae),
      .QUAD_ENABLE_I(qen), .ENHANCED_LATENCY_TABLE_I(elt), .LATENCY_CODE_I(lc),
      .CONTINUOUS_MODE_O(cont), .MEM_ADDR_O(maddr), .MEM_RDATA_I(mem_byte(maddr)),
      .MEM_RVALID_I(rvalid), .MEM_RREADY_O(rready));

   qodfr_host_model h (.sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .oe_o(h_oe),
      .io_i(wire_io), .dev_oe_i(dev_oe));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Rare random stalls from the array side; a zero-dummy read needs its first byte
   // within a few clocks of the address, so frequent stalls would starve it
   always @(posedge clk) rvalid <= (3'($random(seed)) != 3'h0);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   task automatic cmp_data(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t data got %h exp %h", $time, g, e);
      end
   endtask : cmp_data

   task automatic cmp_oe(input logic [3:0] g, input logic [3:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t enable got %h exp %h", $time, g, e);
      end
   endtask : cmp_oe

   task automatic cmp_mode(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t mode got %h exp %h", $time, g, e);
      end
   endtask : cmp_mode

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   // One frame; the bench works out width, dummies and data on its own
   task automatic run(input bit qv, input bit fv, input bit ev, input logic [1:0] lv,
         input bit use_cmd, input logic [7:0] cmd, input logic [31:0] ad,
         input logic [7:0] mode, input int nb, input logic [3:0] oe_exp, input logic c_exp);
      bit dual;
      int nab;
      int dum;
      logic [24:0] st;
      dual = cmd == qodfr_pkg::DUAL_IO_READ_CMD || cmd == qodfr_pkg::DUAL_IO_READ_WIDE_ADDR_CMD;
      nab = (fv || cmd[0] == 1'b0) ? 32 : 24;
      dum = !dual ? int'(qodfr_pkg::QUAD_DUMMY_TBL[lv]) : ev ?
         int'(qodfr_pkg::DUAL_EH_DUMMY_TBL[lv]) : int'(qodfr_pkg::DUAL_HP_DUMMY_TBL[lv]);
      st = (nab == 24) ? {1'b0, ad[23:0]} : ad[24:0];
      @(posedge clk);
      qen <= qv;
      fbae <= fv;
      elt <= ev;
      lc <= lv;
      @(posedge clk);
      // Offset so that no link pin moves at a sampling edge
      #1;
      h.frame(use_cmd, cmd, nab, ad, dual, dual && ev, mode, dum, nb);
      cmp_oe(h.oe_seen, oe_exp);
      if (oe_exp != 4'h0) foreach (h.got[i]) cmp_data(h.got[i], mem_byte(st + 25'(i)));
      cmp_mode(cont, c_exp);
   endtask : run

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      fbae = 1'b0;
      qen = 1'b0;
      elt = 1'b0;
      lc = 2'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      a = 32'($random(seed)) & 32'h01ffffff;
      run(1, 0, 0, 2'h0, 1, qodfr_pkg::QUAD_OUTPUT_READ_CMD, a, 8'h0, 3, 4'hf, 0);
      run(1, 1, 0, 2'h3, 1, qodfr_pkg::QUAD_OUTPUT_READ_CMD, a, 8'h0, 3, 4'hf, 0);
      run(1, 0, 0, 2'h1, 1, qodfr_pkg::QUAD_OUTPUT_READ_WIDE_ADDR_CMD,
         32'h01fffffe, 8'h0, 4, 4'hf, 0);
      run(0, 0, 0, 2'h0, 1, qodfr_pkg::QUAD_OUTPUT_READ_CMD, a, 8'h0, 2, 4'h0, 0);
      run(1, 0, 0, 2'h2, 1, 8'h03, a, 8'h0, 2, 4'h0, 0);
      run(1, 0, 0, 2'h2, 1, qodfr_pkg::DUAL_IO_READ_CMD, a, 8'h0, 3, 4'h3, 0);
      for (int k = 0; k < 4; k++) begin
         a = 32'($random(seed)) & 32'h01ffffff;
         run(1, 0, 1, 2'(k), 1, qodfr_pkg::DUAL_IO_READ_WIDE_ADDR_CMD,
            a, 8'h3c, 2, 4'h3, 0);
      end
      run(1, 0, 1, 2'h2, 1, qodfr_pkg::DUAL_IO_READ_CMD, a, 8'ha5, 2, 4'h3, 1);
      run(1, 0, 1, 2'h2, 0, qodfr_pkg::DUAL_IO_READ_CMD, a, 8'h7f, 2, 4'h3, 0);
      run(1, 0, 1, 2'h1, 1, qodfr_pkg::DUAL_IO_READ_CMD, a, 8'ha0, 2, 4'h3, 1);
      h.glitch(6);
      cmp_mode(cont, 1'b0);
      run(1, 0, 0, 2'h3, 1, qodfr_pkg::QUAD_OUTPUT_READ_CMD, a, 8'h0, 2, 4'hf, 0);
      report_and_stop();
   end

   initial begin
      #500000;
      errors++;
      report_and_stop();
   end
endmodule : tb_qodfr_read
